// [logic/hbim_pkg.sv]
package hbim_pkg;

   // ------------------------------------------------------------------
   // widths and clock
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W      = 11;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned REF_CLK_HZ  = 10_000_000;
   localparam int unsigned SYNC_STAGES = 2;
   localparam logic [1:0]  CAPTURE_WAIT = 2'h3;

   // ------------------------------------------------------------------
   // strap codes {family, timing}
   // ------------------------------------------------------------------
   localparam logic [1:0] STRAP_SYNC_B  = 2'h3;
   localparam logic [1:0] STRAP_ASYNC_B = 2'h2;
   localparam logic [1:0] STRAP_SYNC_A  = 2'h1;
   localparam logic [1:0] STRAP_ASYNC_A = 2'h0;

   typedef enum logic [1:0] {
      HBIM_M_ASYNC_A,
      HBIM_M_SYNC_A,
      HBIM_M_ASYNC_B,
      HBIM_M_SYNC_B
   } hbim_mode_t;

   // ------------------------------------------------------------------
   // device decode and byte order
   // ------------------------------------------------------------------
   localparam logic [4:0]        MUX_ZERO_BITS = 5'h00;
   localparam logic [ADDR_W-1:0] SWAP_TOP      = 11'h010;
   localparam logic [ADDR_W-1:0] SWAP_MASK     = 11'h001;
   localparam int unsigned       DIV_FAST      = 2;
   localparam int unsigned       DIV_SLOW      = 4;

   // ------------------------------------------------------------------
   // host bus timing
   // ------------------------------------------------------------------
   localparam int unsigned STROBE_PER_DIV = 4;
   localparam int unsigned STROBE_HZ      = REF_CLK_HZ / (DIV_SLOW * STROBE_PER_DIV);
   localparam logic [6:0]  STROBE_HALF_CYC = 7'(REF_CLK_HZ / STROBE_HZ / 2);
   localparam logic [6:0]  ALE_HIGH_CYC   = 7'h02;
   localparam logic [6:0]  ALE_HOLD_CYC   = 7'h02;
   localparam logic [6:0]  SETUP_CYC      = 7'h02;
   localparam logic [6:0]  TIMEOUT_CYC    = 7'h40;

   // ------------------------------------------------------------------
   // host register map (byte addresses) and fields
   // ------------------------------------------------------------------
   localparam logic [3:0] HREG_CMD  = 4'h0;
   localparam logic [3:0] HREG_STAT = 4'h4;
   localparam logic [3:0] HREG_CFG  = 4'h8;
   localparam int unsigned CMD_WDATA_LSB = 16;
   localparam int unsigned CMD_WRITE_BIT = 24;
   localparam int unsigned STAT_RDATA_LSB = 8;
   localparam logic       CFG_FAM_RST  = 1'b0;
   localparam logic       CFG_SYNC_RST = 1'b0;

endpackage : hbim_pkg

// [logic/hbim_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface hbim_if;
   logic [10:0] address_lines;
   logic [7:0]  host_data_out;
   logic        host_data_oe;
   logic [7:0]  dev_data_out;
   logic        dev_data_oe;
   logic [7:0]  data_lines;
   logic        wr_eclk;
   logic        rd_rw;
   logic        ale;
   logic        device_select_n;
   logic        dev_done;
   logic        dev_done_oe;
   logic        access_done_handshake;
   logic        divided_clock_out;

   // undriven lines float to a pulled-up level
   assign data_lines = dev_data_oe  ? dev_data_out  :
                       host_data_oe ? host_data_out : 8'hff;
   assign access_done_handshake = dev_done_oe & dev_done;

   modport dev_mp (
      input  address_lines, data_lines, wr_eclk, rd_rw, ale, device_select_n,
      output dev_data_out, dev_data_oe, dev_done, dev_done_oe, divided_clock_out
   );
   modport host_mp (
      output address_lines, host_data_out, host_data_oe, wr_eclk, rd_rw, ale,
      output device_select_n,
      input  data_lines, access_done_handshake, divided_clock_out
   );
endinterface : hbim_if
`default_nettype wire

// [logic/hbim_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module hbim_sync
   import hbim_pkg::*;
#(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '1
)(
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // ------------------------------------------------------------------
   // two-stage synchroniser, one per bit
   // ------------------------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic [SYNC_STAGES-1:0] st_r;
      always_ff @(posedge ref_clk) begin
         if (!resetn) begin
            st_r <= {SYNC_STAGES{RST_VAL[i]}};
         end else begin
            st_r <= {st_r[SYNC_STAGES-2:0], d[i]};
         end
      end
      assign q[i] = st_r[SYNC_STAGES-1];
   end
endmodule : hbim_sync
`default_nettype wire

// [logic/hbim_dev.sv]
`timescale 1ns/10ps
`default_nettype none
module hbim_dev
   import hbim_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   input  wire logic              cpu_family_strap,
   input  wire logic              timing_strap,
   input  wire logic              divider_strap,
   hbim_if.dev_mp                 bus,
   output logic                   user_req,
   output logic                   user_we,
   output logic [ADDR_W-1:0]      user_addr,
   output logic [DATA_W-1:0]      user_wdata,
   input  wire logic [DATA_W-1:0] user_rdata,
   input  wire logic              user_ack,
   output logic                   mode_valid,
   output hbim_mode_t             mode
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      HBIM_D_IDLE,
      HBIM_D_WAIT,
      HBIM_D_HOLD
   } hbim_dstate_t;

   typedef struct packed {
      hbim_dstate_t      st;
      logic [1:0]        cap_cnt;
      logic              mode_ok;
      hbim_mode_t        mode;
      logic              div_fast;
      logic [DATA_W-1:0] low_address_byte;
      logic              ale_d;
      logic              req;
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic              drive;
      logic              done;
      logic              done_oe;
      logic [1:0]        div_cnt;
      logic              clk_out;
   } hbim_dev_t;

   localparam hbim_dev_t DEV_RST = '{
      st:               HBIM_D_IDLE,
      cap_cnt:          2'h0,
      mode_ok:          1'b0,
      mode:             HBIM_M_ASYNC_A,
      div_fast:         1'b0,
      low_address_byte: 8'hff,
      ale_d:            1'b0,
      req:              1'b0,
      we:               1'b0,
      addr:             11'h000,
      wdata:            8'h00,
      rdata:            8'h00,
      drive:            1'b0,
      done:             1'b0,
      done_oe:          1'b0,
      div_cnt:          2'h0,
      clk_out:          1'b0
   };

   hbim_dev_t r;
   hbim_dev_t n;

   // ------------------------------------------------------------------
   // pin synchronisation
   // ------------------------------------------------------------------
   localparam int unsigned SYNC_W = ADDR_W + DATA_W + 7;

   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic [ADDR_W-1:0] address_s;
   logic [DATA_W-1:0] data_s;
   logic              wr_eclk_s;
   logic              rd_rw_s;
   logic              ale_s;
   logic              sel_n_s;
   logic              fam_s;
   logic              tim_s;
   logic              div_s;

   assign pins_raw = {bus.address_lines, bus.data_lines, bus.wr_eclk, bus.rd_rw, bus.ale,
                      bus.device_select_n, cpu_family_strap, timing_strap, divider_strap};

   hbim_sync #(
      .W       (SYNC_W),
      .RST_VAL ({SYNC_W{1'b1}})
   ) u_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .d       (pins_raw),
      .q       (pins_s)
   );

   assign {address_s, data_s, wr_eclk_s, rd_rw_s, ale_s, sel_n_s, fam_s, tim_s, div_s} = pins_s;

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   logic              fam_b;
   logic              async_m;
   logic              muxed;
   logic              rd_strobe;
   logic              wr_strobe;
   logic              selected;
   logic [2:0]        window_select_bits;
   logic [ADDR_W-1:0] host_addr;
   logic [ADDR_W-1:0] mapped_addr;

   assign fam_b   = (r.mode == HBIM_M_SYNC_B) || (r.mode == HBIM_M_ASYNC_B);
   assign async_m = (r.mode == HBIM_M_ASYNC_A) || (r.mode == HBIM_M_ASYNC_B);
   assign muxed   = (r.mode == HBIM_M_SYNC_A);

   // second family: bus clock high qualifies a read/write line
   assign rd_strobe = fam_b ? (wr_eclk_s & rd_rw_s)  : ~rd_rw_s;
   assign wr_strobe = fam_b ? (wr_eclk_s & ~rd_rw_s) : ~wr_eclk_s;

   assign window_select_bits = r.low_address_byte[2:0];

   // the select pin is ignored in muxed mode, the board ties it inactive
   assign selected = muxed ? (r.low_address_byte[7:3] == MUX_ZERO_BITS)
                           : ~sel_n_s;

   assign host_addr = muxed ? {address_s[10:8], r.low_address_byte[7:3], window_select_bits}
                            : address_s;

   // only the 16-bit register area is swapped, memory bytes stay in place
   assign mapped_addr = (fam_b && (host_addr < SWAP_TOP)) ? (host_addr ^ SWAP_MASK)
                                                          : host_addr;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      n     = r;
      n.req = 1'b0;

      // straps are taken once, after the synchroniser has filled
      if (!r.mode_ok) begin
         if (r.cap_cnt == CAPTURE_WAIT) begin
            n.mode_ok  = 1'b1;
            n.div_fast = div_s;
            case ({fam_s, tim_s})
               STRAP_SYNC_B:  n.mode = HBIM_M_SYNC_B;
               STRAP_ASYNC_B: n.mode = HBIM_M_ASYNC_B;
               STRAP_SYNC_A:  n.mode = HBIM_M_SYNC_A;
               default:       n.mode = HBIM_M_ASYNC_A;
            endcase
         end else begin
            n.cap_cnt = r.cap_cnt + 2'h1;
         end
      end

      // handshake pin only driven in the asynchronous modes
      n.done_oe = r.mode_ok && async_m;

      // low address byte captured on the falling latch strobe
      n.ale_d = ale_s;
      if (muxed && r.ale_d && !ale_s) begin
         n.low_address_byte = data_s;
      end

      case (r.st)
         HBIM_D_IDLE: begin
            n.drive = 1'b0;
            n.done  = 1'b0;
            if (r.mode_ok && selected && (rd_strobe || wr_strobe)) begin
               n.req   = 1'b1;
               n.we    = wr_strobe;
               n.addr  = mapped_addr;
               n.wdata = data_s;
               n.st    = HBIM_D_WAIT;
            end
         end
         HBIM_D_WAIT: begin
            if (user_ack) begin
               n.rdata = user_rdata;
               n.drive = ~r.we;
               n.done  = async_m;
               n.st    = HBIM_D_HOLD;
            end
         end
         HBIM_D_HOLD: begin
            // answer held until the host drops strobe or select
            if (!(rd_strobe || wr_strobe) || !selected) begin
               n.drive = 1'b0;
               n.done  = 1'b0;
               n.st    = HBIM_D_IDLE;
            end
         end
         default: begin
            n.st = HBIM_D_IDLE;
         end
      endcase

      // clock for the host, divider strap taken with the mode straps
      n.div_cnt = r.div_cnt + 2'h1;
      n.clk_out = r.div_fast ? n.div_cnt[0] : n.div_cnt[1];
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         r <= DEV_RST;
      end else begin
         r <= n;
      end
   end

   assign bus.dev_data_out      = r.rdata;
   assign bus.dev_data_oe       = r.drive;
   assign bus.dev_done          = r.done;
   assign bus.dev_done_oe       = r.done_oe;
   assign bus.divided_clock_out = r.clk_out;
   assign user_req              = r.req;
   assign user_we               = r.we;
   assign user_addr             = r.addr;
   assign user_wdata            = r.wdata;
   assign mode_valid            = r.mode_ok;
   assign mode                  = r.mode;

endmodule : hbim_dev
`default_nettype wire

// [logic/hbim_host.sv]
`timescale 1ns/10ps
`default_nettype none
module hbim_host
   import hbim_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   hbim_if.host_mp          bus
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      HBIM_H_IDLE,
      HBIM_H_ALE,
      HBIM_H_SETUP,
      HBIM_H_STROBE,
      HBIM_H_END
   } hbim_hstate_t;

   typedef struct packed {
      hbim_hstate_t      st;
      logic [6:0]        cnt;
      logic              fam_b;
      logic              sync_t;
      logic              we;
      logic [DATA_W-1:0] rdata;
      logic              busy;
      logic              timeout;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic [DATA_W-1:0] wdata;
      logic              doe;
      logic              wr_eclk;
      logic              rd_rw;
      logic              ale;
      logic              sel_n;
      logic              wait_r;
      logic [31:0]       rd_word;
   } hbim_host_t;

   localparam hbim_host_t HOST_RST = '{
      st: HBIM_H_IDLE, cnt: 7'h00, fam_b: CFG_FAM_RST, sync_t: CFG_SYNC_RST,
      we: 1'b0, rdata: 8'h00, busy: 1'b0, timeout: 1'b0, addr: 11'h000,
      dout: 8'h00, wdata: 8'h00, doe: 1'b0, wr_eclk: 1'b1, rd_rw: 1'b1, ale: 1'b0,
      sel_n: 1'b1, wait_r: 1'b1, rd_word: 32'h0000_0000
   };

   hbim_host_t r;
   hbim_host_t n;

   // ------------------------------------------------------------------
   // device pins into the host clock
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] data_s;
   logic              ready_s;
   logic              muxed;

   hbim_sync #(
      .W       (DATA_W + 1),
      .RST_VAL ({(DATA_W + 1){1'b0}})
   ) u_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .d       ({bus.data_lines, bus.access_done_handshake}),
      .q       ({data_s, ready_s})
   );

   assign muxed = !r.fam_b && r.sync_t;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      n        = r;
      n.wait_r = 1'b1;
      n.cnt    = r.cnt + 7'h01;

      // one wait cycle, then a single-cycle answer
      if ((avs_read || avs_write) && r.wait_r) begin
         n.wait_r  = 1'b0;
         n.rd_word = 32'h0000_0000;
         if (avs_read) begin
            if (avs_address == HREG_STAT) begin
               n.rd_word = {16'h0000, r.rdata, 6'h00, r.timeout, r.busy};
            end else if (avs_address == HREG_CFG) begin
               n.rd_word = {30'h0000_0000, r.sync_t, r.fam_b};
            end
         end else if (!r.busy) begin
            // writes while busy are dropped
            if (avs_address == HREG_CFG) begin
               n.fam_b  = avs_writedata[0];
               n.sync_t = avs_writedata[1];
            end else if (avs_address == HREG_CMD) begin
               n.busy    = 1'b1;
               n.timeout = 1'b0;
               n.we      = avs_writedata[CMD_WRITE_BIT];
               n.addr    = avs_writedata[ADDR_W-1:0];
               // kept here, the bus master may move on before the data phase
               n.wdata   = avs_writedata[CMD_WDATA_LSB +: DATA_W];
               n.cnt     = 7'h00;
               n.sel_n   = muxed;
               if (muxed) begin
                  n.dout = avs_writedata[DATA_W-1:0];
                  n.doe  = 1'b1;
                  n.ale  = 1'b1;
                  n.st   = HBIM_H_ALE;
               end else begin
                  n.dout = avs_writedata[CMD_WDATA_LSB +: DATA_W];
                  n.doe  = avs_writedata[CMD_WRITE_BIT];
                  n.rd_rw = r.fam_b ? ~avs_writedata[CMD_WRITE_BIT] : 1'b1;
                  n.st   = HBIM_H_SETUP;
               end
            end
         end
      end

      case (r.st)
         HBIM_H_IDLE: begin
            // idle levels must not undo a command taken in this cycle
            if (!n.busy) begin
               n.wr_eclk = ~r.fam_b;
               n.rd_rw   = 1'b1;
               n.doe     = 1'b0;
               n.sel_n   = 1'b1;
            end
         end
         HBIM_H_ALE: begin
            if (r.cnt == ALE_HIGH_CYC - 7'h01) begin
               n.ale = 1'b0;
            end
            if (r.cnt == ALE_HIGH_CYC + ALE_HOLD_CYC - 7'h01) begin
               n.dout = r.wdata;
               n.doe  = r.we;
               n.cnt  = 7'h00;
               n.st   = HBIM_H_SETUP;
            end
         end
         HBIM_H_SETUP: begin
            if (r.cnt == SETUP_CYC - 7'h01) begin
               n.cnt = 7'h00;
               n.st  = HBIM_H_STROBE;
               if (r.fam_b) begin
                  n.wr_eclk = 1'b1;
               end else if (r.we) begin
                  n.wr_eclk = 1'b0;
               end else begin
                  n.rd_rw = 1'b0;
               end
            end
         end
         HBIM_H_STROBE: begin
            // fixed timing: strobe held for half the bus clock period (bus clock high in the second family)
            if ((r.sync_t && r.cnt == STROBE_HALF_CYC - 7'h01) ||
                (!r.sync_t && (ready_s || r.cnt == TIMEOUT_CYC - 7'h01))) begin
               n.rdata   = r.we ? r.rdata : data_s;
               n.timeout = !r.sync_t && !ready_s;
               n.wr_eclk = ~r.fam_b;
               n.rd_rw   = r.fam_b ? ~r.we : 1'b1;
               n.doe     = 1'b0;
               n.cnt     = 7'h00;
               n.st      = HBIM_H_END;
            end
         end
         HBIM_H_END: begin
            if ((r.sync_t && r.cnt == STROBE_HALF_CYC - 7'h01) ||
                (!r.sync_t && (!ready_s || r.cnt == TIMEOUT_CYC - 7'h01))) begin
               n.sel_n = 1'b1;
               n.busy  = 1'b0;
               n.st    = HBIM_H_IDLE;
            end
         end
         default: begin
            n.st = HBIM_H_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         r <= HOST_RST;
      end else begin
         r <= n;
      end
   end

   assign avs_readdata        = r.rd_word;
   assign avs_waitrequest     = r.wait_r;
   assign bus.address_lines   = r.addr;
   assign bus.host_data_out   = r.dout;
   assign bus.host_data_oe    = r.doe;
   assign bus.wr_eclk         = r.wr_eclk;
   assign bus.rd_rw           = r.rd_rw;
   assign bus.ale             = r.ale;
   assign bus.device_select_n = r.sel_n;

endmodule : hbim_host
`default_nettype wire

// [testbench/hbim_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module hbim_assertions
   import hbim_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic       host_data_oe,
   input wire logic       dev_data_oe,
   input wire logic       dev_done_oe,
   input wire logic       ale,
   input wire logic       wr_eclk,
   input wire logic       device_select_n,
   input wire logic       access_done_handshake,
   input wire logic       mode_valid,
   input wire hbim_mode_t mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire logic sa  = mode_valid && mode == HBIM_M_SYNC_A;
   wire logic asy = mode_valid && (mode == HBIM_M_ASYNC_A || mode == HBIM_M_ASYNC_B);
   a_no_fight: assert property (!(dev_data_oe && host_data_oe))
      else $error("data lines driven by both ends");
   a_sync_done: assert property (mode_valid && !asy |-> !dev_done_oe)
      else $error("handshake driven in fixed timing");
   a_sel_drive: assert property ($rose(dev_data_oe) && !sa |-> !device_select_n)
      else $error("device drove data unselected");
   a_mux_sel: assert property (sa |-> device_select_n)
      else $error("select low in muxed mode");
   a_ale_width: assert property ($rose(ale) |-> ale[*2] ##1 !ale)
      else $error("latch strobe width");
   a_done_hold: assert property ($rose(access_done_handshake) |-> access_done_handshake[*3])
      else $error("handshake dropped early");
   a_eclk_len: assert property ($rose(wr_eclk) && mode_valid && mode == HBIM_M_SYNC_B
      |-> wr_eclk[*8] ##1 !wr_eclk)
      else $error("bus clock high phase length");
   a_data_done: assert property ($rose(dev_data_oe) && asy |-> access_done_handshake)
      else $error("read data without handshake");
   c_done: cover property ($rose(access_done_handshake));
   c_ale: cover property ($rose(ale));
   c_read: cover property ($rose(dev_data_oe));
endmodule : hbim_assertions
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb
   import hbim_pkg::*;
();
   logic        ref_clk       = 1'b0;
   logic        resetn        = 1'b0;
   logic        fam           = 1'b0;
   logic        tim           = 1'b0;
   logic        dvs           = 1'b0;
   logic [3:0]  avs_address   = 4'h0;
   logic        avs_read      = 1'b0;
   logic        avs_write     = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        user_req;
   logic        user_we;
   logic [10:0] user_addr;
   logic [7:0]  user_wdata;
   logic [7:0]  user_rdata    = 8'h00;
   logic        user_ack      = 1'b0;
   logic        mode_valid;
   hbim_mode_t  mode;
   int          err_total     = 0;
   int          compares      = 0;
   int          n_req         = 0;
   always #50 ref_clk = ~ref_clk;
   // ack one cycle after the request: fixed timing modes sample soon
   always @(posedge ref_clk) begin
      user_ack <= user_req;
      user_rdata <= ~user_addr[7:0];
      if (user_req === 1'b1) n_req <= n_req + 1;
   end
   hbim_if link ();
   hbim_dev i_hbim_dev (.ref_clk(ref_clk), .resetn(resetn), .cpu_family_strap(fam),
      .timing_strap(tim), .divider_strap(dvs), .bus(link), .user_req(user_req),
      .user_we(user_we), .user_addr(user_addr), .user_wdata(user_wdata),
      .user_rdata(user_rdata), .user_ack(user_ack), .mode_valid(mode_valid), .mode(mode));
   hbim_host i_hbim_host (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(link));
   hbim_assertions i_hbim_assertions (.ref_clk(ref_clk), .resetn(resetn),
      .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe),
      .dev_done_oe(link.dev_done_oe), .ale(link.ale), .wr_eclk(link.wr_eclk),
      .device_select_n(link.device_select_n), .mode_valid(mode_valid), .mode(mode),
      .access_done_handshake(link.access_done_handshake));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task chk_m(input hbim_mode_t got, input hbim_mode_t exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_m
   task av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      avs_write <= w;
      avs_read <= ~w;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   task access(input logic [31:0] cmd, output logic [31:0] st);
      int k;
      av(1'b1, HREG_CMD, cmd, st);
      for (k = 0; k < 200; k++) begin
         av(1'b0, HREG_STAT, 32'h0000_0000, st);
         if (st[0] === 1'b0) break;
      end
   endtask : access
   task run_mode(input logic f, input logic t);
      logic [31:0] st;
      logic [10:0] ea;
      logic        l;
      int          i;
      int          r0;
      int          r1;
      resetn <= 1'b0;
      fam <= f;
      tim <= t;
      dvs <= f ^ t;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      for (i = 0; i < 20 && mode_valid !== 1'b1; i++) @(posedge ref_clk);
      chk_m(mode, hbim_mode_t'(f ? (t ? HBIM_M_SYNC_B : HBIM_M_ASYNC_B)
                                 : (t ? HBIM_M_SYNC_A : HBIM_M_ASYNC_A)));
      // skip the cycles where the divider may still be switching over
      repeat (4) @(posedge ref_clk);
      r0 = -1;
      r1 = -1;
      l = 1'b1;
      for (i = 0; i < 24; i++) begin
         @(posedge ref_clk);
         if (link.divided_clock_out === 1'b1 && l === 1'b0 && r0 >= 0 && r1 < 0) r1 = i;
         if (link.divided_clock_out === 1'b1 && l === 1'b0 && r0 < 0) r0 = i;
         l = link.divided_clock_out;
      end
      chk(32'(r1 - r0), (f ^ t) ? 32'h0000_0002 : 32'h0000_0004);
      av(1'b1, HREG_CFG, {30'h0000_0000, t, f}, st);
      access({7'h00, 1'b1, 8'h5a, 5'h00, 11'h005}, st);
      ea = f ? 11'h004 : 11'h005;
      chk({12'h000, user_we, user_wdata, user_addr}, {12'h000, 1'b1, 8'h5a, ea});
      access(32'h0000_0006, st);
      ea = f ? 11'h007 : 11'h006;
      chk({4'h0, st[1], st[15:8], user_we, 7'h00, user_addr}, {5'h00, ~ea[7:0], 8'h00, ea});
   endtask : run_mode
   task test_sync_b;
      run_mode(1'b1, 1'b1);
      $display("test sync_b done");
   endtask : test_sync_b
   task test_async_b;
      run_mode(1'b1, 1'b0);
      $display("test async_b done");
   endtask : test_async_b
   task test_sync_a;
      logic [31:0] st;
      int          n0;
      run_mode(1'b0, 1'b1);
      // latched bits 7..3 not zero: the decoder must stay quiet
      n0 = n_req;
      access(32'h0000_0046, st);
      chk(32'(n_req - n0), 32'h0000_0000);
      $display("test sync_a done");
   endtask : test_sync_a
   task test_async_a;
      run_mode(1'b0, 1'b0);
      $display("test async_a done");
   endtask : test_async_a
   task close_out;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      test_sync_b;
      test_async_b;
      test_sync_a;
      test_async_a;
      close_out;
   end
   // four modes need well under 4000 cycles
   initial begin
      #1_000_000;
      err_total++;
      close_out;
   end
endmodule : tb
`default_nettype wire
